// file: tmr_pkg.sv
/*
 * Constants for the 8-bit timer with one compare unit: register byte
 * offsets, field positions, reset values and mode encodings.
 * Assumes a 32-bit AXI4-Lite register bus; registers are one word each.
 */
package tmr_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_CONTROL = 5'h00;
	localparam logic [4:0] OFS_COUNT = 5'h04;
	localparam logic [4:0] OFS_COMPARE = 5'h08;
	localparam logic [4:0] OFS_IRQ_FLAG = 5'h0C;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
	// Control register fields
	localparam int CS_LSB = 0;
	localparam int WM_LSB = 3;
	localparam int COM_LSB = 5;
	localparam int FORCE_BIT = 7;
	// Flag and mask bit positions
	localparam int OVF_BIT = 0;
	localparam int CMP_BIT = 1;
	// Reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] COMPARE_RST = 8'h00;
	localparam logic [1:0] FLAG_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	// Extreme counter values
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	// Waveform modes
	localparam logic [1:0] WM_NORMAL = 2'h0;
	localparam logic [1:0] WM_PHASE_PWM = 2'h1;
	localparam logic [1:0] WM_CLEAR_ON_MATCH = 2'h2;
	localparam logic [1:0] WM_FAST_PWM = 2'h3;
	// Compare output modes
	localparam logic [1:0] COM_NONE = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	// Clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	// Prescaler taps (low bits of the prescaler counter that must all be one)
	localparam logic [9:0] PRE_MASK8 = 10'h007;
	localparam logic [9:0] PRE_MASK64 = 10'h03F;
	localparam logic [9:0] PRE_MASK256 = 10'h0FF;
	localparam logic [9:0] PRE_MASK1024 = 10'h3FF;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: tmr_timer8.sv
/*
 * 8-bit timer/counter with one compare unit, four waveform modes,
 * a prescaler, an external event input and an AXI4-Lite register slave.
 * Assumes one clock; the event pin is asynchronous and is synchronised
 * here. The CPU side supplies the global interrupt enable and one
 * service pulse per interrupt.
 */
// Notes on behaviour
// - Counter is 8 bits; max flagged at 0xFF
// - Bottom indication whenever counter equals zero
// - Top is 0xFF or compare, per mode
// - Clock select picks prescaler or event edge
// - Clock select zero stops the counter
// - Each tick clears, increments or decrements
// - Software counter write beats count and clear
// - Mode bits set sequence and overflow point
// - Flags share a register; each has mask
// - Equality match sets compare flag next tick
// - Compare request needs enable, global, flag
// - Compare flag clears on service or write-one
// - Output built from match, modes, extremes
// - Compare double buffered in PWM modes only
// - Buffered compare loads at top (0xFF) only
// - Software reaches buffer when buffering, else active
// - Force strobe acts as match in non-PWM modes, no flag
// - Counter write blocks match next tick
// - Output state kept across mode changes
// - Output mode changes act at once
// - Normal mode counts up, overflow at wrap
// - Clear-on-match mode clears counter at match
// - Fast PWM single slope, set/clear by mode
// - Output mode zero leaves output unchanged
module tmr_timer8 (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic event_clock_pin,
	input wire logic global_irq_enable,
	input wire logic overflow_irq_ack,
	input wire logic compare_irq_ack,
	output logic overflow_irq,
	output logic compare_irq,
	output logic compare_out,
	output logic compare_out_en
);
	// Bus state
	logic aw_held_reg;
	logic [4:0] aw_addr_reg;
	logic w_held_reg;
	logic [7:0] w_data_reg;
	logic w_strb0_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	// Timer state
	logic [7:0] control_reg;
	logic [7:0] count_reg;
	logic [7:0] compare_reg;
	logic [7:0] compare_buf_reg;
	logic [1:0] flag_reg;
	logic [1:0] mask_reg;
	logic [9:0] pre_reg;
	logic ev_meta_reg;
	logic ev_sync_reg;
	logic ev_last_reg;
	logic block_reg;
	logic down_reg;
	logic out_reg;

	wire logic [2:0] clock_select = control_reg[tmr_pkg::CS_LSB +: 3];
	wire logic [1:0] wave_mode = control_reg[tmr_pkg::WM_LSB +: 2];
	wire logic [1:0] compare_out_mode = control_reg[tmr_pkg::COM_LSB +: 2];
	wire logic overflow_flag = flag_reg[tmr_pkg::OVF_BIT];
	wire logic compare_flag = flag_reg[tmr_pkg::CMP_BIT];
	wire logic compare_irq_enable = mask_reg[tmr_pkg::CMP_BIT];

	// Write happens once address and data are both held
	wire logic wr_go = aw_held_reg && w_held_reg && !bvalid_reg && clk_en;
	wire logic wr_en = wr_go && w_strb0_reg;
	wire logic wr_ctrl = wr_en && aw_addr_reg == tmr_pkg::OFS_CONTROL;
	wire logic wr_count = wr_en && aw_addr_reg == tmr_pkg::OFS_COUNT;
	wire logic wr_cmp = wr_en && aw_addr_reg == tmr_pkg::OFS_COMPARE;
	wire logic wr_flag = wr_en && aw_addr_reg == tmr_pkg::OFS_IRQ_FLAG;
	wire logic wr_mask = wr_en && aw_addr_reg == tmr_pkg::OFS_IRQ_MASK;
	wire logic wr_hit = wr_go && (aw_addr_reg == tmr_pkg::OFS_CONTROL
		|| aw_addr_reg == tmr_pkg::OFS_COUNT
		|| aw_addr_reg == tmr_pkg::OFS_COMPARE
		|| aw_addr_reg == tmr_pkg::OFS_IRQ_FLAG
		|| aw_addr_reg == tmr_pkg::OFS_IRQ_MASK);
	wire logic force_strobe = wr_ctrl && w_data_reg[tmr_pkg::FORCE_BIT];

	// Handshake outputs: one outstanding write and read each
	assign s_axi_awready = !aw_held_reg && !bvalid_reg && clk_en;
	assign s_axi_wready = !w_held_reg && !bvalid_reg && clk_en;
	assign s_axi_arready = !rvalid_reg && clk_en;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	// Timer clock selection
	wire logic ev_rise = ev_sync_reg && !ev_last_reg;
	wire logic ev_fall = !ev_sync_reg && ev_last_reg;
	logic timer_tick;
	always_comb
	begin
		case (clock_select)
			tmr_pkg::CS_STOP: timer_tick = 1'b0;
			tmr_pkg::CS_DIV1: timer_tick = 1'b1;
			tmr_pkg::CS_DIV8:
				timer_tick = (pre_reg & tmr_pkg::PRE_MASK8) == tmr_pkg::PRE_MASK8;
			tmr_pkg::CS_DIV64:
				timer_tick = (pre_reg & tmr_pkg::PRE_MASK64)
					== tmr_pkg::PRE_MASK64;
			tmr_pkg::CS_DIV256:
				timer_tick = (pre_reg & tmr_pkg::PRE_MASK256)
					== tmr_pkg::PRE_MASK256;
			tmr_pkg::CS_DIV1024: timer_tick = pre_reg == tmr_pkg::PRE_MASK1024;
			tmr_pkg::CS_EXT_FALL: timer_tick = ev_fall;
			tmr_pkg::CS_EXT_RISE: timer_tick = ev_rise;
			default: timer_tick = 1'b0;
		endcase
	end
	wire logic tick = timer_tick && clk_en;

	// Extremes, mode decode and comparator
	wire logic at_max = count_reg == tmr_pkg::CNT_MAX;
	wire logic at_bottom = count_reg == tmr_pkg::CNT_BOTTOM;
	wire logic pwm_mode = wave_mode == tmr_pkg::WM_PHASE_PWM
		|| wave_mode == tmr_pkg::WM_FAST_PWM;
	wire logic is_phase = wave_mode == tmr_pkg::WM_PHASE_PWM;
	// Top is the compare value only in clear-on-match mode
	wire logic at_top = (wave_mode == tmr_pkg::WM_CLEAR_ON_MATCH)
		? count_reg == compare_reg : at_max;
	// Blocking keeps a just-written count equal to compare silent
	wire logic match = count_reg == compare_reg && !block_reg;
	wire logic match_tick = tick && match;

	// Count sequence per mode
	logic [7:0] count_next;
	logic down_next;
	always_comb
	begin
		count_next = count_reg;
		down_next = down_reg;
		if (is_phase)
		begin
			// Turn at the extremes, step the other way in the same tick
			if (at_max)
				down_next = 1'b1;
			else if (at_bottom)
				down_next = 1'b0;
			count_next = down_next ? count_reg - 8'h01
				: count_reg + 8'h01;
		end
		else if (wave_mode == tmr_pkg::WM_CLEAR_ON_MATCH && match)
			count_next = tmr_pkg::CNT_BOTTOM;
		else
			count_next = count_reg + 8'h01;
	end

	// Overflow point: wrap from max, or bottom in phase-correct mode
	wire logic ovf_set = tick && (is_phase ? at_bottom : at_max);

	// Force uses the modes written with it, so one write sets and forces
	wire logic [1:0] force_com = w_data_reg[tmr_pkg::COM_LSB +: 2];
	wire logic [1:0] force_wm = w_data_reg[tmr_pkg::WM_LSB +: 2];
	wire logic force_go = force_strobe && force_wm != tmr_pkg::WM_PHASE_PWM
		&& force_wm != tmr_pkg::WM_FAST_PWM;

	// Waveform generator
	logic out_next;
	always_comb
	begin
		out_next = out_reg;
		if (force_go)
		begin
			case (force_com)
				tmr_pkg::COM_TOGGLE: out_next = !out_reg;
				tmr_pkg::COM_CLEAR: out_next = 1'b0;
				tmr_pkg::COM_SET: out_next = 1'b1;
				default: out_next = out_reg;
			endcase
		end
		else if (compare_out_mode == tmr_pkg::COM_NONE)
			out_next = out_reg;
		else if (!pwm_mode)
		begin
			if (match_tick)
			begin
				case (compare_out_mode)
					tmr_pkg::COM_TOGGLE: out_next = !out_reg;
					tmr_pkg::COM_CLEAR: out_next = 1'b0;
					tmr_pkg::COM_SET: out_next = 1'b1;
					default: out_next = out_reg;
				endcase
			end
		end
		else if (compare_out_mode != tmr_pkg::COM_TOGGLE)
		begin
			// Bottom edge wins over a match at the same tick
			if (!is_phase && tick && at_max)
				out_next = compare_out_mode == tmr_pkg::COM_CLEAR;
			else if (match_tick)
				out_next = is_phase
					? ((compare_out_mode == tmr_pkg::COM_CLEAR) == down_next)
					: compare_out_mode == tmr_pkg::COM_SET;
		end
	end

	// Interrupt requests; global enable comes from the CPU
	assign overflow_irq = overflow_flag && mask_reg[tmr_pkg::OVF_BIT]
		&& global_irq_enable;
	assign compare_irq = compare_flag && compare_irq_enable
		&& global_irq_enable;
	// Output mode acts on the pin override at once
	assign compare_out = out_reg;
	assign compare_out_en = compare_out_mode != tmr_pkg::COM_NONE;

	// Flag next state: hardware set wins over any clear
	logic [1:0] flag_next;
	always_comb
	begin
		flag_next = flag_reg;
		if (wr_flag)
			flag_next = flag_next & ~w_data_reg[1:0];
		if (overflow_irq_ack)
			flag_next[tmr_pkg::OVF_BIT] = 1'b0;
		if (compare_irq_ack)
			flag_next[tmr_pkg::CMP_BIT] = 1'b0;
		if (ovf_set)
			flag_next[tmr_pkg::OVF_BIT] = 1'b1;
		if (match_tick)
			flag_next[tmr_pkg::CMP_BIT] = 1'b1;
	end

	// Read data mux; compare reads follow the same path as writes
	wire logic [7:0] cmp_view = pwm_mode ? compare_buf_reg : compare_reg;
	logic [7:0] rd_byte;
	logic rd_ok;
	always_comb
	begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			tmr_pkg::OFS_CONTROL:
				rd_byte = control_reg & ~(8'h01 << tmr_pkg::FORCE_BIT);
			tmr_pkg::OFS_COUNT: rd_byte = count_reg;
			tmr_pkg::OFS_COMPARE: rd_byte = cmp_view;
			tmr_pkg::OFS_IRQ_FLAG: rd_byte = {6'h00, flag_reg};
			tmr_pkg::OFS_IRQ_MASK: rd_byte = {6'h00, mask_reg};
			default:
			begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	// Write channel capture
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 5'h00;
			w_held_reg <= 1'b0;
			w_data_reg <= 8'h00;
			w_strb0_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_held_reg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata[7:0];
				w_strb0_reg <= s_axi_wstrb[0];
			end
			else if (wr_go)
				w_held_reg <= 1'b0;
		end
	end

	// Write and read responses
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= tmr_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= tmr_pkg::RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end
		else if (clk_en)
		begin
			if (wr_go)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_reg <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
			begin
				rvalid_reg <= 1'b1;
				rdata_reg <= {24'h000000, rd_byte};
				rresp_reg <= rd_ok ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end

	// Event pin synchroniser; edge detect compares the second stage with its delayed copy
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ev_meta_reg <= 1'b0;
			ev_sync_reg <= 1'b0;
			ev_last_reg <= 1'b0;
			pre_reg <= 10'h000;
		end
		else if (clk_en)
		begin
			ev_meta_reg <= event_clock_pin;
			ev_sync_reg <= ev_meta_reg;
			ev_last_reg <= ev_sync_reg;
			pre_reg <= pre_reg + 10'h001;
		end
	end

	// Control, mask and flags
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			control_reg <= tmr_pkg::CONTROL_RST;
			mask_reg <= tmr_pkg::MASK_RST;
			flag_reg <= tmr_pkg::FLAG_RST;
		end
		else if (clk_en)
		begin
			if (wr_ctrl)
				control_reg <= w_data_reg & ~(8'h01 << tmr_pkg::FORCE_BIT);
			if (wr_mask)
				mask_reg <= w_data_reg[1:0];
			flag_reg <= flag_next;
		end
	end

	// Counter, direction and match blocking
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			count_reg <= tmr_pkg::COUNT_RST;
			down_reg <= 1'b0;
			block_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_count)
				count_reg <= w_data_reg;
			else if (tick)
				count_reg <= count_next;
			if (tick && !wr_count)
				down_reg <= is_phase ? down_next : 1'b0;
			// Block lasts until the tick after the write
			if (wr_count)
				block_reg <= 1'b1;
			else if (tick)
				block_reg <= 1'b0;
		end
	end

	// Compare register and its buffer
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			compare_reg <= tmr_pkg::COMPARE_RST;
			compare_buf_reg <= tmr_pkg::COMPARE_RST;
		end
		else if (clk_en)
		begin
			if (wr_cmp)
				compare_buf_reg <= w_data_reg;
			if (wr_cmp && !pwm_mode)
				compare_reg <= w_data_reg;
			else if (pwm_mode && tick && at_top)
				compare_reg <= compare_buf_reg;
		end
	end

	// Output state survives mode changes; only the generator moves it
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			out_reg <= 1'b0;
		else if (clk_en)
			out_reg <= out_next;
	end
endmodule

// file: tmr_timer8_assertions.sv
/* Concurrent checks on the timer's bus handshakes, freeze input and
   interrupt gating. Sees only top-level ports; bound in at the foot. */
module tmr_timer8_assertions (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic global_irq_enable,
	input wire logic overflow_irq,
	input wire logic compare_irq,
	input wire logic compare_out
);
	// One clock domain; reset voids every check
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	a_frozen_ready: assert property (!clk_en |-> !s_axi_awready
		&& !s_axi_wready && !s_axi_arready) else $error("ready while frozen");
	a_out_frozen: assert property (!clk_en |=> $stable(compare_out))
		else $error("output moved while frozen");
	a_write_latency: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_latency: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	a_read_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("wide data");
	a_irq_gated: assert property (
		!global_irq_enable |-> !overflow_irq && !compare_irq)
		else $error("request without global enable");
endmodule
bind tmr_timer8 tmr_timer8_assertions chk_i (.*);

// file: test_timer8_single_compare_pwm.sv
/* Self-checking bench for the 8-bit timer: bus, stop, modes, flags,
   interrupts, force strobe, buffering and the event input.
   Assumes tmr_pkg and tmr_timer8 are compiled first. */
module test_timer8_single_compare_pwm;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] CTL = tmr_pkg::OFS_CONTROL;
	localparam logic [4:0] CNT = tmr_pkg::OFS_COUNT;
	localparam logic [4:0] CMP = tmr_pkg::OFS_COMPARE;
	localparam logic [4:0] FLG = tmr_pkg::OFS_IRQ_FLAG;
	localparam logic [4:0] MSK = tmr_pkg::OFS_IRQ_MASK;
	// Inputs idle at time zero; the bench is always ready for answers
	logic clock = 1'h0, rst = 1'h1, clk_en = 1'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
	logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic event_clock_pin = 1'h0, global_irq_enable = 1'h0;
	logic overflow_irq_ack = 1'h0, compare_irq_ack = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, overflow_irq, compare_irq;
	logic compare_out, compare_out_en;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int fails = 0;
	int total_checks = 0;
	tmr_timer8 dut (.*);
	// 250 MHz clock
	initial
		forever #2 clock = ~clock;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			fails++;
			$display("CHECK FAILED at %0t: %h, want %h", $time, s, e);
		end
	endtask
	task automatic run(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Both write channels offered together; each dropped once taken
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do
		begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1);
		chk(s_axi_bresp, a > MSK ? 2'h2 : 2'h0);
	endtask
	task automatic rc(input logic [4:0] a, input logic [7:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do
		begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1);
		v = s_axi_rdata;
		chk(s_axi_rresp, a > MSK ? 2'h2 : 2'h0);
		chk(v[7:0], e);
	endtask
	task automatic t_regs;
		rc(CTL, 8'h00);
		rc(CNT, 8'h00);
		wr(MSK, 8'h03);
		rc(MSK, 8'h03);
		wr(5'h14, 8'h01);
		rc(5'h14, 8'h00);
		wr(CNT, 8'h12);
		clk_en <= 1'h0;
		run(4);
		clk_en <= 1'h1;
		run(16);
		rc(CNT, 8'h12);
		$display("regs and stop done");
	endtask
	task automatic t_normal;
		wr(CMP, 8'h02);
		wr(CNT, 8'hF8);
		wr(CTL, 8'h01);
		run(20);
		wr(CTL, 8'h00);
		rc(FLG, 8'h03);
		global_irq_enable <= 1'h1;
		run(2);
		chk({overflow_irq, compare_irq}, 2'h3);
		global_irq_enable <= 1'h0;
		run(2);
		chk(compare_irq, 1'h0);
		global_irq_enable <= 1'h1;
		compare_irq_ack <= 1'h1;
		run(1);
		compare_irq_ack <= 1'h0;
		run(1);
		chk({overflow_irq, compare_irq}, 2'h2);
		wr(FLG, 8'h01);
		rc(FLG, 8'h00);
		global_irq_enable <= 1'h0;
		$display("normal done");
	endtask
	// A counter write equal to compare must not raise the flag
	task automatic t_ctc;
		wr(CMP, 8'h40);
		wr(CNT, 8'h40);
		wr(CTL, 8'h01);
		run(10);
		wr(CTL, 8'h00);
		rc(FLG, 8'h00);
		wr(CMP, 8'h03);
		wr(CNT, 8'h00);
		wr(CTL, 8'h11);
		run(40);
		wr(CTL, 8'h00);
		rc(FLG, 8'h02);
		rc(CNT, 8'h03);
		chk(v[7:0] <= 8'h03, 1'h1);
		wr(FLG, 8'h02);
		rc(FLG, 8'h00);
		$display("clear on match done");
	endtask
	task automatic t_force;
		logic [1:0] com [3] = '{2'h3, 2'h2, 2'h1};
		logic [2:0] ex = 3'h5;
		for (int i = 0; i < 3; i++)
		begin
			wr(CTL, {1'h1, com[i], 5'h00});
			chk({compare_out_en, compare_out}, {1'h1, ex[i]});
		end
		wr(CTL, 8'h80);
		chk({compare_out_en, compare_out}, 2'h1);
		wr(CTL, 8'h18);
		chk(compare_out, 1'h1);
		rc(FLG, 8'h00);
		$display("force done");
	endtask
	// Compare goes via the buffer in fast PWM, loaded at the top
	task automatic t_pwm;
		wr(CTL, 8'h00);
		wr(CMP, 8'h05);
		wr(CTL, 8'h18);
		wr(CMP, 8'h40);
		rc(CMP, 8'h40);
		wr(CTL, 8'h00);
		rc(CMP, 8'h05);
		wr(CNT, 8'hFE);
		wr(CTL, 8'h19);
		run(6);
		wr(CTL, 8'h00);
		rc(CMP, 8'h40);
		wr(CNT, 8'h3A);
		wr(CTL, 8'h59);
		run(12);
		wr(CTL, 8'h58);
		chk(compare_out, 1'h0);
		wr(CNT, 8'hFD);
		wr(CTL, 8'h59);
		run(5);
		wr(CTL, 8'h00);
		chk(compare_out, 1'h1);
		// Phase-correct turns at the top and steps down
		wr(CNT, 8'hFD);
		wr(CTL, 8'h09);
		run(3);
		wr(CTL, 8'h00);
		rc(CNT, 8'hFB);
		overflow_irq_ack <= 1'h1;
		run(1);
		overflow_irq_ack <= 1'h0;
		run(1);
		rc(FLG, 8'h02);
		wr(FLG, 8'h03);
		$display("pwm done");
	endtask
	task automatic pulse(input int n);
		repeat (n)
		begin
			event_clock_pin <= 1'h1;
			run(5);
			event_clock_pin <= 1'h0;
			run(5);
		end
	endtask
	task automatic t_event;
		wr(CNT, 8'h00);
		wr(CTL, 8'h07);
		pulse(3);
		wr(CTL, 8'h00);
		rc(CNT, 8'h03);
		wr(CNT, 8'h00);
		wr(CTL, 8'h06);
		pulse(2);
		wr(CTL, 8'h00);
		rc(CNT, 8'h02);
		$display("event done");
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence after a 12-cycle reset
	initial
	begin
		run(12);
		rst <= 1'h0;
		run(1);
		t_regs();
		t_normal();
		t_ctc();
		t_force();
		t_pwm();
		t_event();
		test_done();
	end
	// Watchdog; the run needs well under 2000 cycles
	initial
	begin
		run(20000);
		fails++;
		test_done();
	end
endmodule
